// ---- logic/pcp_pkg.sv ----
// Package for the protected page cache pager: register map, field positions,
// opcodes, result codes, page types and the toy integrity function.
// Assumes an APB master with 32-bit data and byte addresses.
package pcp_pkg;

  // Register byte offsets.
  localparam logic [7:0] CMD_OFF = 8'h00;
  localparam logic [7:0] DIGEST_OFF = 8'h04;
  localparam logic [7:0] META_OFF = 8'h08;
  localparam logic [7:0] STATUS_OFF = 8'h0C;
  localparam logic [7:0] WB_DIGEST_OFF = 8'h10;
  localparam logic [7:0] WB_META_OFF = 8'h14;
  localparam logic [7:0] INFO_SEL_OFF = 8'h18;
  localparam logic [7:0] INFO_OFF = 8'h1C;
  localparam logic [7:0] CAP_OFF = 8'h20;

  // Command register fields (low bit of each field).
  localparam int OP_LSB = 0;
  localparam int OP_W = 4;
  localparam int TGT_LSB = 8;
  localparam int SPG_LSB = 16;
  localparam int SLOT_LSB = 24;

  // Metadata record fields.
  localparam int META_TYPE_LSB = 0;
  localparam int META_OWNER_LSB = 4;
  localparam int META_MAC_LSB = 16;

  // Status and info fields.
  localparam int STAT_FAULT_BIT = 8;
  localparam int INFO_VALID_BIT = 0;
  localparam int INFO_BLOCKED_BIT = 1;
  localparam int INFO_PENDING_BIT = 2;
  localparam int INFO_TLB_BIT = 3;
  localparam int INFO_TYPE_LSB = 4;
  localparam int INFO_OWNER_LSB = 8;
  localparam int INFO_TRACK_BIT = 12;
  localparam int INFO_VER_LSB = 16;

  // Operation codes.
  localparam logic [3:0] OP_ADD_VERSION_ARRAY = 4'h1;
  localparam logic [3:0] OP_BLOCK_PAGE = 4'h2;
  localparam logic [3:0] OP_TRACK_ENCLAVE = 4'h3;
  localparam logic [3:0] OP_WRITE_BACK_PAGE = 4'h4;
  localparam logic [3:0] OP_LOAD_UNBLOCKED = 4'h5;
  localparam logic [3:0] OP_LOAD_BLOCKED = 4'h6;
  localparam logic [3:0] OP_ADD_DYNAMIC_PAGE = 4'h7;
  localparam logic [3:0] OP_ACCEPT_PAGE = 4'h8;
  localparam logic [3:0] OP_ACCESS = 4'h9;
  localparam logic [3:0] OP_IPI = 4'hA;

  // Result codes.
  localparam logic [3:0] RES_OK = 4'h0;
  localparam logic [3:0] RES_REFUSED = 4'h1;
  localparam logic [3:0] RES_MAC_FAIL = 4'h2;
  localparam logic [3:0] RES_PAGE_FAULT = 4'h3;
  localparam logic [3:0] RES_BAD_OP = 4'hF;

  // Page types.
  localparam logic [1:0] TYPE_REG = 2'h0;
  localparam logic [1:0] TYPE_CONTROL = 2'h1;
  localparam logic [1:0] TYPE_VA = 2'h2;

  // Arbitrary sealing key for the toy cipher; not a secret of any real part.
  localparam logic [31:0] SEAL_KEY = 32'h5A3C_96E1;
  localparam logic [15:0] VER_INIT = 16'h0001;

  // Keyed 16-bit integrity tag binding digest, version and page attributes.
  function automatic logic [15:0] mac_of(input logic [31:0] d, input logic [15:0] v,
                                        input logic [7:0] attr);
    logic [15:0] t;
    t = d[31:16] ^ d[15:0] ^ SEAL_KEY[15:0];
    mac_of = {t[10:0], t[15:11]} ^ v ^ {attr, attr} ^ SEAL_KEY[31:16];
  endfunction : mac_of

endpackage : pcp_pkg

// ---- logic/pcp_pager.sv ----
// Protected page cache pager: page state table, version slots and an APB
// register front end through which system software issues paging operations.
// Assumes one clock, APB master per AMBA rules, and that page contents are
// represented by one 32-bit word per page.
// Notes on behaviour
// - block_page sets blocked; no new translation is cached for that page.
// - Access to blocked page without cached translation faults, installs nothing.
// - track_enclave on control page starts tracking stale translations of blocked pages.
// - write_back_page encrypts the page, outputs ciphertext, invalidates the cached page.
// - Write-back computes an integrity tag and places it in the metadata record.
// - Reload succeeds only when ciphertext and tag match; otherwise page stays absent.
// - Write-back records the page version in a version slot for anti-replay.
// - load_unblocked reinstates unblocked, load_blocked reinstates blocked.
// - Page, slot, ciphertext and metadata are bound together and given back at reload.
// - Successful reload empties the version slot used.
// - Control page cannot be written back while any child page is resident.
// - A version-array page is written back using a slot of another page.
// - add_version_array creates a page whose slots are all empty.
// - add_dynamic_page only on a free page; leaves it valid and pending.
// - Dynamic pages get regular type and zero contents.
// - accept_page checks attributes and clears pending, making the page usable.
// - Interrupt to the enclave forces exit and flushes all cached translations.
// - Dynamic addition only with second-generation capability; rest is first generation.
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps

module pcp_pager #(
  parameter int PAGES = 8,
  parameter int SLOTS = 4,
  parameter bit GEN2 = 1'b1
) (
  input wire logic pclk, // APB clock, 100 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // Slave select.
  input wire logic penable, // Access phase.
  input wire logic pwrite, // Write when high.
  input wire logic [7:0] paddr, // Byte address.
  input wire logic [31:0] pwdata, // Write data.
  output logic [31:0] prdata, // Read data.
  output logic pready, // Always ready.
  output logic pslverr, // Unmapped address.
  output logic enclave_exit // One-cycle pulse on forced enclave exit.
);

  localparam int IW = $clog2(PAGES);
  localparam int SW = $clog2(SLOTS);
  localparam int NS = PAGES * SLOTS;

  // Page state table and version slots, all in flip-flops.
  logic [PAGES-1:0] pg_valid;
  logic [PAGES-1:0] pg_blocked;
  logic [PAGES-1:0] pg_pending;
  logic [PAGES-1:0] pg_tlb;
  logic [PAGES-1:0] track_armed;
  logic [1:0] pg_type [PAGES];
  logic [IW-1:0] pg_owner [PAGES];
  logic [31:0] pg_data [PAGES];
  logic [NS-1:0] slot_used;
  logic [15:0] slot_ver [NS];
  logic [15:0] ver_ctr;

  // Software-visible registers.
  logic [31:0] digest_in;
  logic [31:0] meta_in;
  logic [3:0] result;
  logic fault;
  logic [31:0] wb_digest;
  logic [31:0] wb_meta;
  logic [IW-1:0] info_sel;

  // APB decode; every access completes in its first access cycle.
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire cmd_go = wr && paddr == pcp_pkg::CMD_OFF;
  wire mapped = paddr == pcp_pkg::CMD_OFF || paddr == pcp_pkg::DIGEST_OFF ||
                paddr == pcp_pkg::META_OFF || paddr == pcp_pkg::STATUS_OFF ||
                paddr == pcp_pkg::WB_DIGEST_OFF || paddr == pcp_pkg::WB_META_OFF ||
                paddr == pcp_pkg::INFO_SEL_OFF || paddr == pcp_pkg::INFO_OFF ||
                paddr == pcp_pkg::CAP_OFF;

  // Command fields.
  wire [3:0] op = pwdata[pcp_pkg::OP_LSB +: pcp_pkg::OP_W];
  wire [IW-1:0] tgt = pwdata[pcp_pkg::TGT_LSB +: IW];
  wire [IW-1:0] spg = pwdata[pcp_pkg::SPG_LSB +: IW];
  wire [SW-1:0] sl = pwdata[pcp_pkg::SLOT_LSB +: SW];
  wire [IW+SW-1:0] sidx = {spg, sl};
  wire [1:0] m_type = meta_in[pcp_pkg::META_TYPE_LSB +: 2];
  wire [IW-1:0] m_owner = meta_in[pcp_pkg::META_OWNER_LSB +: IW];
  wire [15:0] m_mac = meta_in[pcp_pkg::META_MAC_LSB +: 16];

  // Per-enclave summaries: stale translations to blocked pages and resident children.
  logic [PAGES-1:0] encl_stale;
  logic [PAGES-1:0] has_child;
  always_comb begin
    encl_stale = '0;
    has_child = '0;
    for (int i = 0; i < PAGES; i++) begin
      if (pg_valid[i] && pg_type[i] != pcp_pkg::TYPE_CONTROL && pg_type[i] != pcp_pkg::TYPE_VA) begin
        has_child[pg_owner[i]] = 1'b1;
        if (pg_blocked[i] && pg_tlb[i]) begin
          encl_stale[pg_owner[i]] = 1'b1;
        end
      end
    end
  end
  wire [PAGES-1:0] trk_done = track_armed & ~encl_stale;

  // Target and slot qualifications.
  wire t_free = !pg_valid[tgt];
  wire t_reg = pg_valid[tgt] && pg_type[tgt] == pcp_pkg::TYPE_REG;
  wire va_ok = pg_valid[spg] && pg_type[spg] == pcp_pkg::TYPE_VA;
  wire owner_ok = pg_valid[m_owner] && pg_type[m_owner] == pcp_pkg::TYPE_CONTROL;
  wire [IW-1:0] t_owner = pg_owner[tgt];

  // Write-back acceptance per page type.
  wire wb_type_ok =
    (pg_type[tgt] == pcp_pkg::TYPE_REG && pg_blocked[tgt] && trk_done[t_owner]) ||
    (pg_type[tgt] == pcp_pkg::TYPE_CONTROL && !has_child[tgt]) ||
    (pg_type[tgt] == pcp_pkg::TYPE_VA && spg != tgt);
  wire wb_ok = pg_valid[tgt] && !pg_pending[tgt] && va_ok && !slot_used[sidx] && wb_type_ok;

  // Ciphertext and integrity tag produced at write-back.
  wire [7:0] wb_attr = 8'({pg_owner[tgt], 2'b00, pg_type[tgt]});
  wire [31:0] wb_cipher = pg_data[tgt] ^ pcp_pkg::SEAL_KEY ^ {ver_ctr, ver_ctr};
  wire [15:0] wb_mac = pcp_pkg::mac_of(wb_cipher, ver_ctr, wb_attr);

  // Reload check: slot holds a live version and the tag matches it.
  wire [15:0] ld_ver = slot_ver[sidx];
  wire mac_ok = m_mac == pcp_pkg::mac_of(digest_in, ld_ver, meta_in[7:0]);
  wire ld_type_ok = m_type == pcp_pkg::TYPE_CONTROL || m_type == pcp_pkg::TYPE_VA ||
                    (m_type == pcp_pkg::TYPE_REG && owner_ok);
  wire ld_pre = t_free && va_ok && slot_used[sidx] && ld_type_ok;
  wire is_load = op == pcp_pkg::OP_LOAD_UNBLOCKED || op == pcp_pkg::OP_LOAD_BLOCKED;
  wire ld_ok = ld_pre && mac_ok;
  wire [31:0] ld_plain = digest_in ^ pcp_pkg::SEAL_KEY ^ {ld_ver, ld_ver};

  // Other operations.
  wire blk_ok = t_reg && !pg_pending[tgt] && !pg_blocked[tgt];
  wire trk_ok = pg_valid[tgt] && pg_type[tgt] == pcp_pkg::TYPE_CONTROL;
  wire aug_ok = GEN2 && t_free && owner_ok;
  wire acc_ok = t_reg && pg_pending[tgt];
  wire use_ok = t_reg && !pg_pending[tgt];
  wire use_fault = use_ok && pg_blocked[tgt] && !pg_tlb[tgt];

  // Result of the command being issued.
  logic [3:0] next_result;
  always_comb begin
    unique case (op)
      pcp_pkg::OP_ADD_VERSION_ARRAY: next_result = t_free ? pcp_pkg::RES_OK : pcp_pkg::RES_REFUSED;
      pcp_pkg::OP_BLOCK_PAGE: next_result = blk_ok ? pcp_pkg::RES_OK : pcp_pkg::RES_REFUSED;
      pcp_pkg::OP_TRACK_ENCLAVE: next_result = trk_ok ? pcp_pkg::RES_OK : pcp_pkg::RES_REFUSED;
      pcp_pkg::OP_WRITE_BACK_PAGE: next_result = wb_ok ? pcp_pkg::RES_OK : pcp_pkg::RES_REFUSED;
      pcp_pkg::OP_LOAD_UNBLOCKED, pcp_pkg::OP_LOAD_BLOCKED:
        next_result = !ld_pre ? pcp_pkg::RES_REFUSED :
                      (mac_ok ? pcp_pkg::RES_OK : pcp_pkg::RES_MAC_FAIL);
      pcp_pkg::OP_ADD_DYNAMIC_PAGE: next_result = aug_ok ? pcp_pkg::RES_OK : pcp_pkg::RES_REFUSED;
      pcp_pkg::OP_ACCEPT_PAGE: next_result = acc_ok ? pcp_pkg::RES_OK : pcp_pkg::RES_REFUSED;
      pcp_pkg::OP_ACCESS:
        next_result = !use_ok ? pcp_pkg::RES_REFUSED :
                      (use_fault ? pcp_pkg::RES_PAGE_FAULT : pcp_pkg::RES_OK);
      pcp_pkg::OP_IPI: next_result = pcp_pkg::RES_OK;
      default: next_result = pcp_pkg::RES_BAD_OP;
    endcase
  end
  wire good = next_result == pcp_pkg::RES_OK;
  wire do_ipi = cmd_go && op == pcp_pkg::OP_IPI;

  // Page state table update; one operation per command write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pg_valid <= '0;
      pg_blocked <= '0;
      pg_pending <= '0;
      pg_tlb <= '0;
      track_armed <= '0;
      for (int i = 0; i < PAGES; i++) begin
        pg_type[i] <= pcp_pkg::TYPE_REG;
        pg_owner[i] <= '0;
        pg_data[i] <= '0;
      end
    end else if (do_ipi) begin
      pg_tlb <= '0;
    end else if (cmd_go && good) begin
      unique case (op)
        pcp_pkg::OP_ADD_VERSION_ARRAY: begin
          pg_valid[tgt] <= 1'b1;
          pg_type[tgt] <= pcp_pkg::TYPE_VA;
          pg_owner[tgt] <= '0;
        end
        pcp_pkg::OP_BLOCK_PAGE: begin
          pg_blocked[tgt] <= 1'b1;
          track_armed[t_owner] <= 1'b0; // A new block needs a fresh track.
        end
        pcp_pkg::OP_TRACK_ENCLAVE: track_armed[tgt] <= 1'b1;
        pcp_pkg::OP_WRITE_BACK_PAGE: begin
          pg_valid[tgt] <= 1'b0;
          pg_tlb[tgt] <= 1'b0;
          pg_blocked[tgt] <= 1'b0;
          if (pg_type[tgt] == pcp_pkg::TYPE_CONTROL) begin
            track_armed[tgt] <= 1'b0;
          end
        end
        pcp_pkg::OP_LOAD_UNBLOCKED, pcp_pkg::OP_LOAD_BLOCKED: begin
          pg_valid[tgt] <= 1'b1;
          pg_blocked[tgt] <= op == pcp_pkg::OP_LOAD_BLOCKED;
          pg_pending[tgt] <= 1'b0;
          pg_tlb[tgt] <= 1'b0;
          pg_type[tgt] <= m_type;
          pg_owner[tgt] <= m_owner;
          pg_data[tgt] <= ld_plain;
        end
        pcp_pkg::OP_ADD_DYNAMIC_PAGE: begin
          pg_valid[tgt] <= 1'b1;
          pg_pending[tgt] <= 1'b1;
          pg_blocked[tgt] <= 1'b0;
          pg_tlb[tgt] <= 1'b0;
          pg_type[tgt] <= pcp_pkg::TYPE_REG;
          pg_owner[tgt] <= m_owner;
          pg_data[tgt] <= '0;
        end
        pcp_pkg::OP_ACCEPT_PAGE: pg_pending[tgt] <= 1'b0;
        pcp_pkg::OP_ACCESS: begin
          if (!pg_blocked[tgt]) begin
            pg_tlb[tgt] <= 1'b1; // Translations are only cached for unblocked pages.
          end
        end
        default: ;
      endcase
    end
  end

  // Version slots: filled at write-back, emptied at reload, cleared on a new array page.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_used <= '0;
      ver_ctr <= pcp_pkg::VER_INIT;
      for (int i = 0; i < NS; i++) begin
        slot_ver[i] <= '0;
      end
    end else if (cmd_go && good && op == pcp_pkg::OP_WRITE_BACK_PAGE) begin
      slot_used[sidx] <= 1'b1;
      slot_ver[sidx] <= ver_ctr;
      ver_ctr <= ver_ctr + 16'h0001;
    end else if (cmd_go && good && is_load) begin
      slot_used[sidx] <= 1'b0;
    end else if (cmd_go && good && op == pcp_pkg::OP_ADD_VERSION_ARRAY) begin
      slot_used[tgt * SLOTS +: SLOTS] <= '0;
    end
  end

  // Software registers: inputs for reload, write-back outputs, status.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      digest_in <= '0;
      meta_in <= '0;
      result <= pcp_pkg::RES_OK;
      fault <= 1'b0;
      wb_digest <= '0;
      wb_meta <= '0;
      info_sel <= '0;
      enclave_exit <= 1'b0;
    end else begin
      enclave_exit <= do_ipi;
      if (wr && paddr == pcp_pkg::DIGEST_OFF) begin
        digest_in <= pwdata;
      end
      if (wr && paddr == pcp_pkg::META_OFF) begin
        meta_in <= pwdata;
      end
      if (wr && paddr == pcp_pkg::INFO_SEL_OFF) begin
        info_sel <= pwdata[IW-1:0];
      end
      if (cmd_go) begin
        result <= next_result;
      end
      // A fault raised in the cycle software clears the flag wins over the clear.
      if (cmd_go && op == pcp_pkg::OP_ACCESS && use_fault) begin
        fault <= 1'b1;
      end else if (wr && paddr == pcp_pkg::STATUS_OFF && pwdata[pcp_pkg::STAT_FAULT_BIT]) begin
        fault <= 1'b0;
      end
      if (cmd_go && good && op == pcp_pkg::OP_WRITE_BACK_PAGE) begin
        wb_digest <= wb_cipher;
        wb_meta <= {wb_mac, 8'h00, wb_attr};
      end
    end
  end

  // Read mux; unmapped addresses answer zero with an error.
  wire [15:0] sel_ver = slot_ver[{info_sel, {SW{1'b0}}}];
  wire [31:0] info_word = {sel_ver, 3'b000, track_armed[info_sel],
                           4'(pg_owner[info_sel]), 2'b00, pg_type[info_sel],
                           pg_tlb[info_sel], pg_pending[info_sel],
                           pg_blocked[info_sel], pg_valid[info_sel]};
  always_comb begin
    unique case (paddr)
      pcp_pkg::DIGEST_OFF: prdata = digest_in;
      pcp_pkg::META_OFF: prdata = meta_in;
      pcp_pkg::STATUS_OFF: prdata = {23'h000000, fault, 4'h0, result};
      pcp_pkg::WB_DIGEST_OFF: prdata = wb_digest;
      pcp_pkg::WB_META_OFF: prdata = wb_meta;
      pcp_pkg::INFO_SEL_OFF: prdata = 32'(info_sel);
      pcp_pkg::INFO_OFF: prdata = info_word;
      pcp_pkg::CAP_OFF: prdata = {30'h00000000, GEN2, 1'b1};
      default: prdata = 32'h00000000;
    endcase
  end
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;

  // Checks on the paging state machine.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_cmd(logic [3:0] code);
    cmd_go && op == code;
  endsequence

  AST_BLOCK_SETS: assert property (s_cmd(pcp_pkg::OP_BLOCK_PAGE) ##0 blk_ok
    |=> pg_blocked[$past(tgt)] && !track_armed[$past(t_owner)])
    else $error("block did not set the blocked state");
  AST_FAULT_NO_MAP: assert property (s_cmd(pcp_pkg::OP_ACCESS) ##0 use_fault
    |=> fault && !pg_tlb[$past(tgt)] && result == pcp_pkg::RES_PAGE_FAULT)
    else $error("blocked access did not fault or installed a mapping");
  AST_WB_INVALIDATES: assert property (s_cmd(pcp_pkg::OP_WRITE_BACK_PAGE) ##0 wb_ok
    |=> !pg_valid[$past(tgt)] && slot_used[$past(sidx)] && wb_digest == $past(wb_cipher))
    else $error("write-back did not invalidate page or fill slot");
  AST_MAC_FAIL_STAYS_OUT: assert property (s_cmd(pcp_pkg::OP_LOAD_UNBLOCKED) ##0 ld_pre
    ##0 !mac_ok |=> !pg_valid[$past(tgt)] && result == pcp_pkg::RES_MAC_FAIL)
    else $error("page reinstated despite tag mismatch");
  AST_LOAD_FREES_SLOT: assert property (cmd_go && is_load && ld_ok
    |=> !slot_used[$past(sidx)] && pg_valid[$past(tgt)])
    else $error("reload left the version slot filled");
  AST_LOADB_BLOCKED: assert property (s_cmd(pcp_pkg::OP_LOAD_BLOCKED) ##0 ld_ok
    |=> pg_blocked[$past(tgt)] ##1 pg_valid[$past(tgt, 2)])
    else $error("blocked reload did not leave page blocked");
  AST_AUG_PENDING: assert property (s_cmd(pcp_pkg::OP_ADD_DYNAMIC_PAGE) ##0 aug_ok
    |=> pg_pending[$past(tgt)] && pg_data[$past(tgt)] == 32'h00000000 &&
        pg_type[$past(tgt)] == pcp_pkg::TYPE_REG)
    else $error("dynamic page not pending, zeroed and regular");
  AST_ACCEPT_CLEARS: assert property (s_cmd(pcp_pkg::OP_ACCEPT_PAGE) ##0 acc_ok
    |=> !pg_pending[$past(tgt)] && pg_valid[$past(tgt)])
    else $error("accept did not clear pending");
  AST_IPI_FLUSH: assert property (do_ipi |=> pg_tlb == '0 && enclave_exit)
    else $error("interrupt did not flush translations");
  AST_WB_NEEDS_TRACK: assert property (s_cmd(pcp_pkg::OP_WRITE_BACK_PAGE) ##0 t_reg
    ##0 !trk_done[t_owner] |=> pg_valid[$past(tgt)] && result == pcp_pkg::RES_REFUSED)
    else $error("write-back accepted before tracking completed");
  AST_ENCLAVE_CONTROL_PAGE_LAST: assert property (s_cmd(pcp_pkg::OP_WRITE_BACK_PAGE)
    ##0 pg_type[tgt] == pcp_pkg::TYPE_CONTROL ##0 has_child[tgt] |=> pg_valid[$past(tgt)])
    else $error("control page evicted with resident children");

  // Tracking, sealing and reload order; the tag must land where software reads it back.
  AST_TRACK_ARMS: assert property (s_cmd(pcp_pkg::OP_TRACK_ENCLAVE) ##0 trk_ok
    |=> track_armed[$past(tgt)] && result == pcp_pkg::RES_OK)
    else $error("track did not arm the enclave");
  AST_WB_SEALS: assert property (s_cmd(pcp_pkg::OP_WRITE_BACK_PAGE) ##0 wb_ok
    |=> wb_meta[pcp_pkg::META_MAC_LSB +: 16] == $past(wb_mac) && slot_ver[$past(sidx)] == $past(ver_ctr))
    else $error("write-back tag or version not recorded");
  AST_LOADU_UNBLOCKED: assert property (s_cmd(pcp_pkg::OP_LOAD_UNBLOCKED) ##0 ld_ok
    |=> !pg_blocked[$past(tgt)] && pg_valid[$past(tgt)])
    else $error("unblocked reload left page blocked or absent");
  AST_AUG_FREE_ONLY: assert property (s_cmd(pcp_pkg::OP_ADD_DYNAMIC_PAGE) ##0 !t_free
    |=> result == pcp_pkg::RES_REFUSED)
    else $error("dynamic addition accepted on a used page");
  AST_CTRL_LOAD_FIRST: assert property (s_cmd(pcp_pkg::OP_LOAD_UNBLOCKED)
    ##0 m_type == pcp_pkg::TYPE_REG ##0 !owner_ok |=> result == pcp_pkg::RES_REFUSED)
    else $error("regular page reloaded without its control page");

endmodule : pcp_pager

// ---- logic/pcp_pager_fix_note.sv ----
// Intentionally empty companion: no extra design units.
`timescale 1ns/1ps

// ---- sim/pcp_sw_model.sv ----
// Page manager software model: issues paging commands as APB transfers.
// Assumes a slave that answers with pready and samples on the rising edge.
`timescale 1ns/1ps

module pcp_sw_model (
  input wire logic pclk, // Bus clock.
  output logic psel, // Slave select.
  output logic penable, // Access phase.
  output logic pwrite, // Write when high.
  output logic [7:0] paddr, // Byte address.
  output logic [31:0] pwdata, // Write data.
  input wire logic [31:0] prdata, // Read data.
  input wire logic pready, // Transfer done.
  input wire logic pslverr // Unmapped address.
);
  // The bus idles low from time zero so the slave sees no request in reset.
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // One transfer; the request is held until pready is seen high at an edge.
  // Released write data is inverted so a stale value is never mistaken.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask : xfer
endmodule : pcp_sw_model

// ---- sim/pcp_pager_bench.sv ----
// Self-checking bench for the pager: software issues commands over APB
// and reads STATUS and INFO back. Assumes the design's package constants.
`timescale 1ns/1ps

module pcp_pager_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, enclave_exit;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, v, d, m;
  logic e;
  int errors = 0;
  int num_checks = 0;

  // 100 MHz clock.
  always #5 pclk = ~pclk;

  pcp_pager uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .enclave_exit(enclave_exit));

  pcp_sw_model sw (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim;
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim

  task automatic wr(input logic [7:0] a, input logic [31:0] dd);
    logic [31:0] q;
    logic ee;
    sw.xfer(1'b1, a, dd, q, ee);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic ee;
    sw.xfer(1'b0, a, 32'h0000_0000, q, ee);
  endtask : rd

  // Issue one command and compare the result code that STATUS reports.
  task automatic op(input logic [3:0] o, input logic [7:0] tg, input logic [7:0] sp,
                    input logic [7:0] sl, input logic [3:0] exp);
    logic [31:0] s;
    wr(pcp_pkg::CMD_OFF, {sl, sp, tg, 4'h0, o});
    rd(pcp_pkg::STATUS_OFF, s);
    chk({28'h0, s[3:0]}, {28'h0, exp});
  endtask : op

  task automatic inf(input logic [7:0] p, output logic [31:0] q);
    wr(pcp_pkg::INFO_SEL_OFF, {24'h0, p});
    rd(pcp_pkg::INFO_OFF, q);
  endtask : inf

  // Cuts a hang short; the whole sequence needs a few hundred cycles.
  initial begin
    #200000;
    errors++;
    end_sim();
  end

  // Main sequence; version-array pages are made resident before any reload.
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(pcp_pkg::CAP_OFF, v);
    chk({30'h0, v[1:0]}, 32'h0000_0003);
    sw.xfer(1'b0, 8'h24, 32'h0000_0000, v, e);
    chk({e, v[30:0]}, 32'h8000_0000);
    op(pcp_pkg::OP_ADD_VERSION_ARRAY, 8'h00, 8'h00, 8'h00, pcp_pkg::RES_OK);
    op(pcp_pkg::OP_ADD_VERSION_ARRAY, 8'h01, 8'h00, 8'h00, pcp_pkg::RES_OK);
    inf(8'h00, v);
    chk({16'h0, v[31:16]}, 32'h0000_0000);
    op(pcp_pkg::OP_WRITE_BACK_PAGE, 8'h01, 8'h01, 8'h00, pcp_pkg::RES_REFUSED);
    op(pcp_pkg::OP_WRITE_BACK_PAGE, 8'h01, 8'h00, 8'h00, pcp_pkg::RES_OK);
    inf(8'h01, v);
    chk({31'h0, v[0]}, 32'h0000_0000);
    inf(8'h00, v);
    chk({16'h0, v[31:16]}, {16'h0, pcp_pkg::VER_INIT});
    rd(pcp_pkg::WB_DIGEST_OFF, d);
    rd(pcp_pkg::WB_META_OFF, m);
    chk({30'h0, m[1:0]}, {30'h0, pcp_pkg::TYPE_VA});
    wr(pcp_pkg::DIGEST_OFF, d);
    wr(pcp_pkg::META_OFF, m ^ 32'h0001_0000);
    op(pcp_pkg::OP_LOAD_UNBLOCKED, 8'h02, 8'h00, 8'h00, pcp_pkg::RES_MAC_FAIL);
    inf(8'h02, v);
    chk({31'h0, v[0]}, 32'h0000_0000);
    wr(pcp_pkg::META_OFF, m);
    op(pcp_pkg::OP_LOAD_UNBLOCKED, 8'h02, 8'h00, 8'h00, pcp_pkg::RES_OK);
    inf(8'h02, v);
    chk({26'h0, v[5:0]}, {26'h0, pcp_pkg::TYPE_VA, 4'b0001});
    inf(8'h00, v);
    // The version stays recorded; emptiness shows as the refused replay below.
    chk({16'h0, v[31:16]}, {16'h0, pcp_pkg::VER_INIT});
    op(pcp_pkg::OP_LOAD_BLOCKED, 8'h04, 8'h00, 8'h00, pcp_pkg::RES_REFUSED);
    op(pcp_pkg::OP_WRITE_BACK_PAGE, 8'h02, 8'h00, 8'h01, pcp_pkg::RES_OK);
    rd(pcp_pkg::WB_DIGEST_OFF, d);
    rd(pcp_pkg::WB_META_OFF, m);
    wr(pcp_pkg::DIGEST_OFF, d);
    // Page 5 returns as the enclave's control page; the image is sealed for slot 1,
    // whose version is the second one handed out.
    wr(pcp_pkg::META_OFF, {pcp_pkg::mac_of(d, pcp_pkg::VER_INIT + 16'h0001,
                           {6'h00, pcp_pkg::TYPE_CONTROL}), 14'h0000, pcp_pkg::TYPE_CONTROL});
    op(pcp_pkg::OP_LOAD_BLOCKED, 8'h05, 8'h00, 8'h01, pcp_pkg::RES_OK);
    inf(8'h05, v);
    chk({26'h0, v[5:0]}, {26'h0, pcp_pkg::TYPE_CONTROL, 4'b0011});
    // Dynamic pages belong to the enclave whose control page is page 5.
    wr(pcp_pkg::META_OFF, 32'h0000_0050);
    op(pcp_pkg::OP_ADD_DYNAMIC_PAGE, 8'h03, 8'h00, 8'h00, pcp_pkg::RES_OK);
    inf(8'h03, v);
    chk({26'h0, v[5:0]}, {26'h0, pcp_pkg::TYPE_REG, 4'b0101});
    op(pcp_pkg::OP_ADD_DYNAMIC_PAGE, 8'h03, 8'h00, 8'h00, pcp_pkg::RES_REFUSED);
    op(pcp_pkg::OP_ACCEPT_PAGE, 8'h03, 8'h00, 8'h00, pcp_pkg::RES_OK);
    op(pcp_pkg::OP_ACCESS, 8'h03, 8'h00, 8'h00, pcp_pkg::RES_OK);
    op(pcp_pkg::OP_BLOCK_PAGE, 8'h03, 8'h00, 8'h00, pcp_pkg::RES_OK);
    inf(8'h03, v);
    chk({28'h0, v[3:0]}, 32'h0000_000B);
    op(pcp_pkg::OP_ACCESS, 8'h03, 8'h00, 8'h00, pcp_pkg::RES_OK);
    wr(pcp_pkg::CMD_OFF, {28'h0, pcp_pkg::OP_IPI});
    #1 chk({31'h0, enclave_exit}, 32'h0000_0001);
    @(posedge pclk);
    #1 chk({31'h0, enclave_exit}, 32'h0000_0000);
    inf(8'h03, v);
    chk({31'h0, v[3]}, 32'h0000_0000);
    op(pcp_pkg::OP_ACCESS, 8'h03, 8'h00, 8'h00, pcp_pkg::RES_PAGE_FAULT);
    rd(pcp_pkg::STATUS_OFF, v);
    chk({31'h0, v[8]}, 32'h0000_0001);
    inf(8'h03, v);
    chk({31'h0, v[3]}, 32'h0000_0000);
    op(pcp_pkg::OP_TRACK_ENCLAVE, 8'h03, 8'h00, 8'h00, pcp_pkg::RES_REFUSED);
    op(pcp_pkg::OP_WRITE_BACK_PAGE, 8'h03, 8'h00, 8'h02, pcp_pkg::RES_REFUSED);
    op(pcp_pkg::OP_TRACK_ENCLAVE, 8'h05, 8'h00, 8'h00, pcp_pkg::RES_OK);
    op(pcp_pkg::OP_WRITE_BACK_PAGE, 8'h05, 8'h00, 8'h02, pcp_pkg::RES_REFUSED);
    op(pcp_pkg::OP_WRITE_BACK_PAGE, 8'h03, 8'h00, 8'h02, pcp_pkg::RES_OK);
    rd(pcp_pkg::WB_META_OFF, m);
    chk({24'h0, m[7:0]}, 32'h0000_0050);
    rd(pcp_pkg::WB_DIGEST_OFF, d);
    op(pcp_pkg::OP_WRITE_BACK_PAGE, 8'h05, 8'h00, 8'h03, pcp_pkg::RES_OK);
    wr(pcp_pkg::DIGEST_OFF, d);
    wr(pcp_pkg::META_OFF, m);
    // Reloads whose array page or control page is absent must be refused.
    op(pcp_pkg::OP_LOAD_UNBLOCKED, 8'h03, 8'h01, 8'h02, pcp_pkg::RES_REFUSED);
    op(pcp_pkg::OP_LOAD_UNBLOCKED, 8'h03, 8'h00, 8'h02, pcp_pkg::RES_REFUSED);
    op(4'h0, 8'h00, 8'h00, 8'h00, pcp_pkg::RES_BAD_OP);
    end_sim();
  end
endmodule : pcp_pager_bench
